// file: scdt_pkg.sv
// Package: shared constants and types for the sample clock delay and timestamp block
`default_nettype none
package scdt_pkg;
  // ***************************************************************
  // Widths and reset values
  // ***************************************************************
  localparam int          SAMPLE_W        = 8;
  localparam int          DELAY_W         = 8;
  localparam int          RAMP_PERIOD     = 256;
  localparam logic [7:0]  RAMP_SLOW_STEP  = 8'h01;
  localparam logic [7:0]  RAMP_FAST_STEP  = 8'h04;
  localparam logic [7:0]  DELAY_RST       = 8'h00;
  localparam int          PIPE_DEPTH      = 3;
  // ***************************************************************
  // Controller register map (APB byte offsets)
  // ***************************************************************
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_DELAY       = 8'h04;
  localparam logic [7:0]  REG_STATUS      = 8'h08;
  localparam int          CTRL_TS_EN      = 0;
  localparam int          CTRL_INV        = 1;
  localparam int          CTRL_RAMP_EN    = 2;
  localparam int          CTRL_RAMP_FAST  = 3;
  localparam int          CTRL_DUAL       = 4;
  localparam int          CTRL_DECIM      = 5;
  localparam int          DLY_COARSE_LSB  = 0;
  localparam int          DLY_FINE_LSB    = 8;
  localparam int          STAT_RAMPING    = 0;
  localparam int          STAT_SYSREF     = 1;
  localparam int          STAT_TS_ACTIVE  = 2;
  localparam int          STAT_CUR_LSB    = 8;
endpackage
`default_nettype wire

// file: scdt_if.sv
// Interface: control link between controller and sampling clock block
`default_nettype none
interface scdt_if;
  import scdt_pkg::*;
  logic               ts_enable;
  logic               sample_clock_invert;
  logic [DELAY_W-1:0] aperture_delay_coarse;
  logic [DELAY_W-1:0] aperture_delay_fine;
  logic               aperture_delay_ramp;
  logic               ramp_fast;
  logic               dual_channel;
  logic               coarse_write;
  logic               ramp_busy;
  logic [DELAY_W-1:0] coarse_applied;
  logic               sysref_seen;
  modport device (
    input  ts_enable, sample_clock_invert, aperture_delay_coarse, aperture_delay_fine,
           aperture_delay_ramp, ramp_fast, dual_channel, coarse_write,
    output ramp_busy, coarse_applied, sysref_seen
  );
  modport ctrl (
    output ts_enable, sample_clock_invert, aperture_delay_coarse, aperture_delay_fine,
           aperture_delay_ramp, ramp_fast, dual_channel, coarse_write,
    input  ramp_busy, coarse_applied, sysref_seen
  );
endinterface
`default_nettype wire

// file: scdt_device.sv
// Device end: sample path with timestamp, aperture delay settings and SYSREF capture
//
// What this block does
// - Timestamp only while enable bit set
// - Output is upper seven bits plus trigger
// - Trigger bit shares the sample pipeline latency
// - Trigger sampled alongside analog input
// - Controller avoids timestamp with decimation modes
// - Device clock drives sampling and serializer
// - Dual mode: one sample per clock
// - Single mode: two samples per clock
// - SYSREF single pulse or periodic
// - Periodic SYSREF at multiframe rate division
// - SYSREF captured on the correct edge
// - Inversion adds half clock period delay
// - Coarse and fine have 256 settings
// - Delay controls independent, total is sum
// - Delay shows on coarse_out and fine_out; SYSREF capture unshifted
// - Live delay change; ramp recommended
// - Ramp coarse one or four per 256
`default_nettype none
module scdt_device
  import scdt_pkg::*;
#(
  parameter int PIPE = PIPE_DEPTH
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  scdt_if.device                   ctl,
  input  wire logic [SAMPLE_W-1:0] conv_rise,
  input  wire logic [SAMPLE_W-1:0] conv_fall,
  input  wire logic                trigger_mark_input,
  input  wire logic                trigger_mark_fall,
  input  wire logic                sysref_in,
  output logic [SAMPLE_W-1:0]      sample_a,
  output logic [SAMPLE_W-1:0]      sample_b,
  output logic                     sample_b_valid,
  output logic                     sysref_capt,
  output logic                     clock_invert_out,
  output logic [DELAY_W-1:0]       coarse_out,
  output logic [DELAY_W-1:0]       fine_out
);
  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [PIPE-1:0][SAMPLE_W-1:0] pipe_a;
    logic [PIPE-1:0][SAMPLE_W-1:0] pipe_b;
    logic [PIPE-1:0]               pipe_bv;
    logic [DELAY_W-1:0]            coarse_cur;
    logic [DELAY_W-1:0]            coarse_tgt;
    logic [DELAY_W-1:0]            fine;
    logic                          inv;
    logic [7:0]                    ramp_cnt;
    logic                          sysref_q;
    logic                          sysref_hit;
  } scdt_dev_st_t;

  scdt_dev_st_t st_q, st_d;

  function automatic logic [SAMPLE_W-1:0] stamp(input logic [SAMPLE_W-1:0] s, input logic trig, input logic en);
    stamp = en ? {s[SAMPLE_W-1:1], trig} : s;
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic [DELAY_W-1:0] step;
    logic [DELAY_W-1:0] gap;
    step = ctl.ramp_fast ? RAMP_FAST_STEP : RAMP_SLOW_STEP;
    gap  = 8'h00;
    st_d = st_q;
    // Sample and trigger bit enter the same stage, so they stay aligned
    st_d.pipe_a[0]  = stamp(conv_rise, trigger_mark_input, ctl.ts_enable);
    st_d.pipe_b[0]  = stamp(conv_fall, trigger_mark_fall, ctl.ts_enable);
    st_d.pipe_bv[0] = ~ctl.dual_channel;
    for (int i = 1; i < PIPE; i++) begin
      st_d.pipe_a[i]  = st_q.pipe_a[i-1];
      st_d.pipe_b[i]  = st_q.pipe_b[i-1];
      st_d.pipe_bv[i] = st_q.pipe_bv[i-1];
    end
    st_d.inv  = ctl.sample_clock_invert;
    st_d.fine = ctl.aperture_delay_fine;
    if (ctl.coarse_write) begin
      st_d.coarse_tgt = ctl.aperture_delay_coarse;
      st_d.ramp_cnt   = 8'h00;
      if (!ctl.aperture_delay_ramp) begin
        st_d.coarse_cur = ctl.aperture_delay_coarse;
      end
    end else if (st_q.coarse_cur != st_q.coarse_tgt) begin
      st_d.ramp_cnt = st_q.ramp_cnt + 8'h01;
      // Step only once every 256 clocks, limiting clock glitches on the link
      if (st_q.ramp_cnt == 8'(RAMP_PERIOD - 1)) begin
        if (st_q.coarse_tgt > st_q.coarse_cur) begin
          gap = st_q.coarse_tgt - st_q.coarse_cur;
          st_d.coarse_cur = (gap < step) ? st_q.coarse_tgt : st_q.coarse_cur + step;
        end else begin
          gap = st_q.coarse_cur - st_q.coarse_tgt;
          st_d.coarse_cur = (gap < step) ? st_q.coarse_tgt : st_q.coarse_cur - step;
        end
      end
    end
    // Capture is a plain register of sysref_in on pclk, independent of the delay setting
    st_d.sysref_q   = sysref_in;
    st_d.sysref_hit = st_q.sysref_hit | (sysref_in & ~st_q.sysref_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign sample_a           = st_q.pipe_a[PIPE-1];
  assign sample_b           = st_q.pipe_b[PIPE-1];
  assign sample_b_valid     = st_q.pipe_bv[PIPE-1];
  assign sysref_capt        = st_q.sysref_q;
  assign clock_invert_out   = st_q.inv;
  assign coarse_out         = st_q.coarse_cur;
  assign fine_out           = st_q.fine;
  assign ctl.ramp_busy      = st_q.coarse_cur != st_q.coarse_tgt;
  assign ctl.coarse_applied = st_q.coarse_cur;
  assign ctl.sysref_seen    = st_q.sysref_hit;
endmodule
`default_nettype wire

// file: scdt_ctrl.sv
// Controller end: APB register file driving the device control link
`default_nettype none
module scdt_ctrl
  import scdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  scdt_if.ctrl             ctl
);
  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [5:0]         ctrl;
    logic [DELAY_W-1:0] coarse;
    logic [DELAY_W-1:0] fine;
    logic               cwr;
    logic [31:0]        rdata;
  } scdt_ctl_st_t;

  scdt_ctl_st_t st_q, st_d;
  logic         acc;
  logic         hit;

  assign acc = psel & penable;
  assign hit = (paddr == REG_CTRL) | (paddr == REG_DELAY) | (paddr == REG_STATUS);

  always_comb begin
    st_d     = st_q;
    st_d.cwr = 1'b0;
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        REG_CTRL:   st_d.rdata = {26'h0, st_q.ctrl};
        REG_DELAY:  st_d.rdata = {16'h0, st_q.fine, st_q.coarse};
        REG_STATUS: st_d.rdata = {16'h0, ctl.coarse_applied, 5'h0, ctl.ts_enable, ctl.sysref_seen, ctl.ramp_busy};
        default:    st_d.rdata = 32'h0;
      endcase
    end
    if (acc & pwrite) begin
      if (paddr == REG_CTRL) begin
        st_d.ctrl = pwdata[5:0];
        // Timestamp is refused while a decimating link format is selected
        if (pwdata[CTRL_DECIM]) begin
          st_d.ctrl[CTRL_TS_EN] = 1'b0;
        end
      end else if (paddr == REG_DELAY) begin
        st_d.coarse = pwdata[DLY_COARSE_LSB +: DELAY_W];
        st_d.fine   = pwdata[DLY_FINE_LSB +: DELAY_W];
        st_d.cwr    = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready                    = 1'b1;
  assign pslverr                   = acc & ~hit;
  assign prdata                    = st_q.rdata;
  assign ctl.ts_enable             = st_q.ctrl[CTRL_TS_EN];
  assign ctl.sample_clock_invert   = st_q.ctrl[CTRL_INV];
  assign ctl.aperture_delay_ramp   = st_q.ctrl[CTRL_RAMP_EN];
  assign ctl.ramp_fast             = st_q.ctrl[CTRL_RAMP_FAST];
  assign ctl.dual_channel          = st_q.ctrl[CTRL_DUAL];
  assign ctl.aperture_delay_coarse = st_q.coarse;
  assign ctl.aperture_delay_fine   = st_q.fine;
  assign ctl.coarse_write          = st_q.cwr;
endmodule
`default_nettype wire

// file: scdt_checker.sv
// Checker: control link assertions between the controller and device ends
`default_nettype none
module scdt_checker
  import scdt_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               aperture_delay_ramp,
  input wire logic               ramp_fast,
  input wire logic               coarse_write,
  input wire logic [DELAY_W-1:0] aperture_delay_coarse,
  input wire logic               ramp_busy,
  input wire logic [DELAY_W-1:0] coarse_applied,
  input wire logic               sysref_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***************************************************************
  // Size of the last move of the applied coarse delay
  // ***************************************************************
  logic [DELAY_W-1:0] prev_q;
  logic [DELAY_W-1:0] step;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_q <= DELAY_RST;
    else prev_q <= coarse_applied;
  end
  // Absolute distance, since a ramp may move up or down
  assign step = (coarse_applied > prev_q) ? coarse_applied - prev_q : prev_q - coarse_applied;
  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_jump_no_ramp: assert property (coarse_write && !aperture_delay_ramp |=>
    coarse_applied == $past(aperture_delay_coarse)) else $error("coarse not applied at once");
  a_busy_clears: assert property (coarse_write && !aperture_delay_ramp |-> ##[2:3] !ramp_busy)
    else $error("busy stays after direct write");
  a_ramp_quiet: assert property (coarse_write && aperture_delay_ramp |=> $stable(coarse_applied)[*8])
    else $error("ramp moved too early");
  a_slow_step: assert property ($changed(coarse_applied) && aperture_delay_ramp && !ramp_fast
    && !$past(coarse_write) |-> step == RAMP_SLOW_STEP) else $error("slow ramp step wrong");
  a_fast_step: assert property ($changed(coarse_applied) && aperture_delay_ramp && ramp_fast
    && !$past(coarse_write) |-> step <= RAMP_FAST_STEP) else $error("fast ramp step too big");
  a_ramp_moves: assert property (ramp_busy && aperture_delay_ramp && !coarse_write |-> ##[1:300]
    ($changed(coarse_applied) || coarse_write || !aperture_delay_ramp)) else $error("ramp stalled");
  a_write_pulse: assert property (coarse_write |=> !coarse_write) else $error("write pulse too long");
  a_sysref_sticky: assert property (sysref_seen |=> sysref_seen) else $error("sysref flag lost");
  cover property (coarse_write && aperture_delay_ramp);
  cover property ($fell(ramp_busy));
  cover property ($rose(sysref_seen));
endmodule
`default_nettype wire

// file: tb_sample_clock_delay_timestamp.sv
// Testbench: controller and device ends joined over the control link
`default_nettype none
module tb_sample_clock_delay_timestamp
  import scdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        trig_r = 1'b0, trig_f = 1'b0, sysref = 1'b0, pready, pslverr, slv, b_valid, capt, inv_o;
  logic [7:0]  paddr = 8'h00, conv_r = 8'h00, conv_f = 8'h00, smp_a, smp_b, crs_o, fin_o;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          error_cnt = 0, checks_done = 0, hits, bad;
  scdt_if      ctl_if();
  always #25 pclk = ~pclk;
  scdt_ctrl scdt_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl(ctl_if.ctrl));
  scdt_device #(.PIPE(PIPE_DEPTH)) scdt_device_i (.pclk(pclk), .presetn(presetn), .ctl(ctl_if.device),
    .conv_rise(conv_r), .conv_fall(conv_f), .trigger_mark_input(trig_r), .trigger_mark_fall(trig_f),
    .sysref_in(sysref), .sample_a(smp_a), .sample_b(smp_b), .sample_b_valid(b_valid), .sysref_capt(capt),
    .clock_invert_out(inv_o), .coarse_out(crs_o), .fine_out(fin_o));
  scdt_checker scdt_checker_i (.pclk(pclk), .presetn(presetn), .aperture_delay_ramp(ctl_if.aperture_delay_ramp),
    .ramp_fast(ctl_if.ramp_fast), .coarse_write(ctl_if.coarse_write), .sysref_seen(ctl_if.sysref_seen),
    .aperture_delay_coarse(ctl_if.aperture_delay_coarse), .ramp_busy(ctl_if.ramp_busy),
    .coarse_applied(ctl_if.coarse_applied));
  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen, giving up after 16 cycles; no fixed wait-state count is assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check(32'(slv), 32'(a > REG_STATUS));
  endtask
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    cyc(16);
    presetn <= 1'b1;
    rdc(REG_CTRL, 32'h0);
    rdc(REG_DELAY, 32'h0);
    rdc(REG_STATUS, 32'h0);
    check(32'({inv_o, crs_o, fin_o}), 32'h0);
    apb(1'b1, 8'h10, 32'hffffffff);
    rdc(8'h0c, 32'h0);
    rdc(REG_CTRL, 32'h0);
    $display("test reset and map done");
    apb(1'b1, REG_CTRL, 32'h11);
    conv_r <= 8'h5a;
    trig_r <= 1'b1;
    cyc(8);
    check(32'(smp_a), 32'h5b);
    check(32'(b_valid), 32'h0);
    conv_r <= 8'h00;
    trig_r <= 1'b0;
    cyc(8);
    // One-cycle mark and data step must leave the pipe together
    conv_r <= 8'hfe;
    trig_r <= 1'b1;
    cyc(1);
    conv_r <= 8'h00;
    trig_r <= 1'b0;
    hits = 0;
    bad = 0;
    repeat (8) begin
      cyc(1);
      hits += int'(smp_a === 8'hff);
      bad += int'(smp_a !== 8'hff && smp_a !== 8'h00);
    end
    check(32'(hits), 32'h1);
    check(32'(bad), 32'h0);
    conv_r <= 8'h5a;
    trig_r <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h10);
    cyc(8);
    check(32'(smp_a), 32'h5a);
    apb(1'b1, REG_CTRL, 32'h31);
    rdc(REG_STATUS, 32'h0);
    cyc(8);
    check(32'(smp_a), 32'h5a);
    apb(1'b1, REG_CTRL, 32'h01);
    conv_f <= 8'hc4;
    trig_f <= 1'b1;
    cyc(8);
    check(32'({b_valid, smp_b, smp_a}), 32'h1c55b);
    $display("test timestamp and modes done");
    apb(1'b1, REG_CTRL, 32'h02);
    apb(1'b1, REG_DELAY, 32'h5aff);
    cyc(4);
    check(32'({inv_o, crs_o, fin_o}), 32'h1ff5a);
    rdc(REG_STATUS, 32'hff00);
    apb(1'b1, REG_CTRL, 32'h0e);
    apb(1'b1, REG_DELAY, 32'h5af7);
    cyc(100);
    rdc(REG_STATUS, 32'hff01);
    cyc(250);
    rdc(REG_STATUS, 32'hfb01);
    cyc(300);
    rdc(REG_STATUS, 32'hf700);
    apb(1'b1, REG_CTRL, 32'h06);
    apb(1'b1, REG_DELAY, 32'h5af9);
    cyc(300);
    rdc(REG_STATUS, 32'hf801);
    cyc(300);
    rdc(REG_STATUS, 32'hf900);
    check(32'({crs_o, fin_o}), 32'hf95a);
    $display("test aperture delay done");
    sysref <= 1'b1;
    cyc(1);
    sysref <= 1'b0;
    cyc(1);
    check(32'(capt), 32'h1);
    cyc(8);
    rdc(REG_STATUS, 32'hf902);
    // Periodic reference pulses keep the flag set and leave the delay alone
    repeat (4) begin
      sysref <= 1'b1;
      cyc(1);
      sysref <= 1'b0;
      cyc(9);
    end
    rdc(REG_STATUS, 32'hf902);
    $display("test sysref done");
    finish_test();
  end
endmodule
`default_nettype wire
